/* bench/alc_aspm_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_aspm_ctrl_asserts #(
    parameter int NPORT   = 4,
    parameter int L0S_CYC = 8,
    parameter int L1_CYC  = 20
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [NPORT-1:0] aspm_l0s_en,
    input  wire logic [NPORT-1:0] aspm_l1_en,
    input  wire logic [NPORT-1:0] link_up,
    input  wire logic [NPORT-1:0] tlp_pending,
    input  wire logic [NPORT-1:0] tlp_credit_ok,
    input  wire logic [NPORT-1:0] acknak_pending,
    input  wire logic [NPORT-1:0] rx_l1_req,
    input  wire logic [NPORT-1:0] rx_eios,
    input  wire logic [NPORT-1:0] tx_l0s,
    input  wire logic [NPORT-1:0] link_l1,
    input  wire logic [NPORT-1:0] send_l1_req,
    input  wire logic [NPORT-1:0] send_pm_ack,
    input  wire logic [NPORT-1:0] send_nak,
    input  wire logic [NPORT-1:0] l1_exit_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_ack_idle;
        (send_pm_ack & rx_eios & link_up) != '0;
    endsequence
    a_nak_single: assert property ((send_nak & $past(send_nak)) == '0)
        else $error("nak longer than one cycle");
    a_ack_cause: assert property ((send_pm_ack & ~$past(send_pm_ack)
        & ~$past(rx_l1_req & aspm_l1_en & ~tlp_pending & ~acknak_pending)) == '0)
        else $error("ack without an acceptable request");
    a_nak_cause: assert property ((send_nak & ~$past(rx_l1_req)) == '0)
        else $error("nak without a request");
    a_ack_hold: assert property (($past(send_pm_ack & ~rx_eios & link_up & ~tlp_pending)
        & ~send_pm_ack) == '0)
        else $error("ack dropped before idle set");
    a_l1_entry: assert property (s_ack_idle |=>
        (($past(send_pm_ack & rx_eios & link_up) & ~link_l1) == '0))
        else $error("no l1 after idle set");
    a_l1_exit_tlp: assert property (($past(link_l1 & tlp_pending & link_up)
        & ~l1_exit_start) == '0)
        else $error("no l1 exit on pending tlp");
    a_l0s_qual: assert property ((tx_l0s & ~$past(tx_l0s) & ($past(tlp_pending
        & tlp_credit_ok, L0S_CYC) | ~$past(aspm_l0s_en))) == '0)
        else $error("l0s entered without qualification");
    a_l0s_exit: assert property (($past(tx_l0s & tlp_pending & tlp_credit_ok & link_up)
        & tx_l0s) == '0)
        else $error("l0s kept with traffic");
    a_l1_req_qual: assert property ((send_l1_req & ~$past(send_l1_req)
        & $past(tlp_pending | ~aspm_l1_en, L1_CYC)) == '0)
        else $error("l1 request without qualification");
endmodule : alc_aspm_ctrl_asserts
bind alc_aspm_ctrl alc_aspm_ctrl_asserts #(.NPORT(NPORT), .L0S_CYC(L0S_CYC), .L1_CYC(L1_CYC))
    u_chk (.clk(clk), .arst_n(arst_n), .aspm_l0s_en(aspm_l0s_en), .aspm_l1_en(aspm_l1_en),
    .link_up(link_up), .tlp_pending(tlp_pending), .tlp_credit_ok(tlp_credit_ok),
    .acknak_pending(acknak_pending), .rx_l1_req(rx_l1_req), .rx_eios(rx_eios),
    .tx_l0s(tx_l0s), .link_l1(link_l1), .send_l1_req(send_l1_req),
    .send_pm_ack(send_pm_ack), .send_nak(send_nak), .l1_exit_start(l1_exit_start));
`default_nettype wire

/* bench/alc_aspm_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_aspm_ctrl_tb;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       decline = 1'b0;
    logic [1:0] l0s_en = '0, l1_en = '0, elec_idle = '0, tlp = '0, acknak = '0, want = '0;
    logic [1:0] l1_req, eios, nak_sent, pm_ack, l1_dec, tx_l0s, rx_l0s, link_l1;
    logic [1:0] send_l1_req, send_pm_ack, send_nak, l1_exit, l0s_exit;
    logic [1:0] active = '1, lnk = '1, credit = '1, dllp = '0;
    logic [1:0] replay = '1, rxidle = '1, maxcred = '1;
    int         err_count = 0;
    int         checks_done = 0;
    int         i;
    always #2.5 clk = ~clk;
    // port 0 is the upstream port, port 1 the downstream port
    alc_aspm_ctrl #(.NPORT(2), .L0S_CYC(8), .L1_CYC(20)) dut (.clk(clk), .arst_n(arst_n),
        .is_upstream(2'b01), .aspm_l0s_en(l0s_en), .aspm_l1_en(l1_en), .port_active(active),
        .link_up(lnk), .rx_elec_idle(elec_idle), .rx_eios(eios), .tlp_pending(tlp),
        .tlp_credit_ok(credit), .dllp_pending(dllp), .acknak_pending(acknak),
        .replay_empty(replay), .rx_idle(rxidle), .max_credit_ok(maxcred), .rx_l1_req(l1_req),
        .rx_pm_ack(pm_ack), .rx_l1_decline(l1_dec), .nak_sent(nak_sent), .tx_l0s(tx_l0s),
        .rx_l0s(rx_l0s), .link_l1(link_l1), .send_l1_req(send_l1_req),
        .send_pm_ack(send_pm_ack), .send_nak(send_nak), .l1_exit_start(l1_exit),
        .l0s_exit_start(l0s_exit));
    alc_link_partner #(.NPORT(2)) u_partner (.clk(clk), .arst_n(arst_n), .want_l1(want),
        .decline(decline), .send_l1_req(send_l1_req), .send_pm_ack(send_pm_ack),
        .send_nak(send_nak), .rx_l1_req(l1_req), .rx_eios(eios), .nak_sent(nak_sent),
        .rx_pm_ack(pm_ack), .rx_l1_decline(l1_dec));
    task step; @(posedge clk); #1; endtask : step
    task chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task t_l0s;
        @(posedge clk) elec_idle <= 2'b11;
        repeat (3) step();
        chk(rx_l0s === 2'b11 && tx_l0s === 2'b00, "rx l0s with tx disabled");
        @(posedge clk) l0s_en <= 2'b11;
        repeat (8) step();
        chk(tx_l0s === 2'b00, "tx l0s too early");
        for (i = 0; i < 10 && tx_l0s !== 2'b11; i++) step();
        chk(tx_l0s === 2'b11, "tx l0s not entered");
        @(posedge clk) tlp <= 2'b10;
        step();
        chk(tx_l0s[1] === 1'b0 && l0s_exit[1] === 1'b1, "downstream l0s exit");
        for (i = 0; i < 3 && tx_l0s[0] !== 1'b0; i++) step();
        chk(tx_l0s[0] === 1'b0, "upstream follows exit");
        @(posedge clk) {tlp, elec_idle, l0s_en} <= '0;
    endtask : t_l0s
    task t_gate;
        @(posedge clk) {l0s_en, elec_idle, dllp, tlp, credit} <= 10'b11_01_10_01_10;
        repeat (14) step();
        chk(tx_l0s === 2'b00, "l0s held by live downstream rx");
        @(posedge clk) lnk <= 2'b01;
        repeat (14) step();
        chk(tx_l0s === 2'b01, "link-down port ignored, no credit idle");
        @(posedge clk) lnk <= 2'b11;
        repeat (3) step();
        chk(tx_l0s === 2'b00, "l0s left on lapse");
        @(posedge clk) active <= 2'b01;
        repeat (14) step();
        chk(tx_l0s === 2'b01, "inactive port ignored");
        @(posedge clk) {l0s_en, elec_idle, dllp, tlp, credit, active} <= 12'b00_00_00_00_11_11;
    endtask : t_gate
    task t_l1;
        @(posedge clk) {l1_en, want, decline} <= {4'b1110, 1'b1};
        @(posedge clk) want <= '0;
        for (i = 0; i < 10 && link_l1[1] !== 1'b1; i++) step();
        chk(link_l1[1] === 1'b1, "downstream accept");
        for (int p = 0; p < 3; p++) begin
            @(posedge clk) {replay, rxidle, maxcred} <= 6'b11_11_11 & ~(6'b01_00_00 >> (2 * p));
            repeat (25) step();
            chk(send_l1_req[0] === 1'b0, "l1 held by idle terms");
        end
        @(posedge clk) {replay, rxidle, maxcred} <= '1;
        for (i = 0; i < 40 && send_l1_req[0] !== 1'b1; i++) step();
        chk(i >= 20 && send_l1_req[0] === 1'b1, "upstream l1 request");
        repeat (3) step();
        chk(link_l1[0] === 1'b0, "decline keeps link out of l1");
        @(posedge clk) decline <= 1'b0;
        for (i = 0; i < 40 && link_l1[0] !== 1'b1; i++) step();
        chk(link_l1[0] === 1'b1, "upstream l1 after ack");
        @(posedge clk) tlp <= 2'b01;
        step();
        chk(l1_exit[0] === 1'b1 && link_l1[0] === 1'b0, "upstream l1 exit");
        for (i = 0; i < 200 && l1_exit[1] !== 1'b1; i++) step();
        chk(l1_exit[1] === 1'b1, "downstream follows l1 exit");
        @(posedge clk) {tlp, l1_en} <= '0;
    endtask : t_l1
    task t_reject;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {l1_en, acknak, want} <= (k == 0) ? 6'b10_10_10 : 6'b00_00_10;
            @(posedge clk) want <= '0;
            for (i = 0; i < 10 && send_nak[1] !== 1'b1; i++) step();
            chk(send_nak[1] === 1'b1, "request rejected");
            step();
            chk(send_nak[1] === 1'b0 && send_pm_ack[1] === 1'b0, "single nak");
            repeat (2000) step();
            chk(link_l1[1] === 1'b0 && send_nak[1] === 1'b0, "no l1 after nak");
        end
    endtask : t_reject
    task complete_run;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) step();
        t_l0s();
        t_gate();
        t_l1();
        t_reject();
        complete_run();
    end
    // whole run is about 4500 cycles
    initial begin
        #100us;
        err_count++;
        complete_run();
    end
endmodule : alc_aspm_ctrl_tb
`default_nettype wire

/* bench/alc_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_link_partner #(
    parameter int NPORT = 2
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [NPORT-1:0] want_l1,
    input  wire logic             decline,
    input  wire logic [NPORT-1:0] send_l1_req,
    input  wire logic [NPORT-1:0] send_pm_ack,
    input  wire logic [NPORT-1:0] send_nak,
    output var  logic [NPORT-1:0] rx_l1_req,
    output var  logic [NPORT-1:0] rx_eios,
    output var  logic [NPORT-1:0] nak_sent,
    output var  logic [NPORT-1:0] rx_pm_ack,
    output var  logic [NPORT-1:0] rx_l1_decline
);
    // new requests only when the bench asks, so spacing after a nak is the bench's job
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {rx_l1_req, rx_eios, nak_sent, rx_pm_ack, rx_l1_decline} <= '0;
        end else begin
            rx_l1_req     <= (rx_l1_req | want_l1) & ~send_pm_ack & ~send_nak;
            rx_eios       <= send_pm_ack;
            nak_sent      <= send_nak;
            rx_pm_ack     <= send_l1_req & {NPORT{~decline}};
            rx_l1_decline <= send_l1_req & {NPORT{decline}};
        end
    end
endmodule : alc_link_partner
`default_nettype wire

/* design/alc_aspm_ctrl.sv */
// What this block does
// - hardware does every aspm transition once enabled
// - transmit and receive l0s handled separately
// - receive l0s follows partner while link up and not in l1
// - tx l0s after conditions hold 7us
// - upstream needs all active downstream rx l0s
// - upstream idle: no tlp or credit, no dllp
// - downstream needs upstream rx l0s and idle
// - upstream leaves l0s on traffic or downstream exit
// - downstream leaves l0s on traffic or upstream exit
// - only upstream starts l1; downstream answers
// - downstream accepts l1 if enabled and idle
// - upstream requests l1 after 1 ms from l0/l0s
// - ack enters l1, decline falls back to l0
// - upstream l1 needs downstreams l1, empty, idle
// - upstream l1 needs credits for largest packets
// - upstream exits l1 on tlp or downstream exit
// - downstream exits l1 on tlp or upstream exit
// - accept sends ack continuously until idle set or a tlp is pending
// - reject sends exactly one nak packet
`timescale 1ns/1ps
`default_nettype none
`include "alc_cfg.svh"

module alc_aspm_ctrl #(
    parameter int NPORT     = 4,
    parameter int L0S_CYC   = `ALC_L0S_QUAL_CYC,
    parameter int L1_CYC    = `ALC_L1_QUAL_CYC,
    parameter int EXIT_CYC  = `ALC_L1_EXIT_CYC,
    parameter int CNT_W     = 18
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    // per port: 1 = upstream port of the partition
    input  wire logic [NPORT-1:0] is_upstream,
    // aspm control field bits of each port's link_control_register
    input  wire logic [NPORT-1:0] aspm_l0s_en,
    input  wire logic [NPORT-1:0] aspm_l1_en,
    input  wire logic [NPORT-1:0] port_active,
    input  wire logic [NPORT-1:0] link_up,
    input  wire logic [NPORT-1:0] rx_elec_idle,
    input  wire logic [NPORT-1:0] rx_eios,
    input  wire logic [NPORT-1:0] tlp_pending,
    input  wire logic [NPORT-1:0] tlp_credit_ok,
    input  wire logic [NPORT-1:0] dllp_pending,
    input  wire logic [NPORT-1:0] acknak_pending,
    input  wire logic [NPORT-1:0] replay_empty,
    input  wire logic [NPORT-1:0] rx_idle,
    input  wire logic [NPORT-1:0] max_credit_ok,
    input  wire logic [NPORT-1:0] rx_l1_req,
    input  wire logic [NPORT-1:0] rx_pm_ack,
    input  wire logic [NPORT-1:0] rx_l1_decline,
    input  wire logic [NPORT-1:0] nak_sent,
    output var  logic [NPORT-1:0] tx_l0s,
    output var  logic [NPORT-1:0] rx_l0s,
    output var  logic [NPORT-1:0] link_l1,
    output var  logic [NPORT-1:0] send_l1_req,
    output var  logic [NPORT-1:0] send_pm_ack,
    output var  logic [NPORT-1:0] send_nak,
    output var  logic [NPORT-1:0] l1_exit_start,
    output var  logic [NPORT-1:0] l0s_exit_start
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // partition members that count for the coordination terms
    function automatic logic all_set(input logic [NPORT-1:0] v,
                                     input logic [NPORT-1:0] m);
        all_set = &(v | ~m);
    endfunction : all_set

    alc_pkg::alc_tx_e st [NPORT];
    alc_pkg::alc_tx_e next_st [NPORT];

    wire [NPORT-1:0] dn_live = ~is_upstream & port_active & link_up;
    wire [NPORT-1:0] up_mask = is_upstream;
    wire [NPORT-1:0] in_l1;
    wire [NPORT-1:0] dn_all_rx_l0s = {NPORT{all_set(rx_l0s, dn_live)}};
    wire [NPORT-1:0] up_rx_l0s = {NPORT{all_set(rx_l0s, up_mask)}};
    wire [NPORT-1:0] dn_all_l1 = {NPORT{all_set(in_l1, dn_live)}};
    wire             any_dn_l0s_exit = |(l0s_exit_start & ~is_upstream);
    wire             any_up_l0s_exit = |(l0s_exit_start & is_upstream);
    wire             any_dn_l1_exit = |(l1_exit_start & ~is_upstream);
    wire             any_up_l1_exit = |(l1_exit_start & is_upstream);

    // tlp blocked when nothing queued or no credit for it
    wire [NPORT-1:0] tx_quiet = (~tlp_pending | ~tlp_credit_ok) & ~dllp_pending;
    // per-port select: a vector condition in a ternary would pick one side for every port
    wire [NPORT-1:0] l0s_cond = aspm_l0s_en & tx_quiet &
                                ((is_upstream & dn_all_rx_l0s) |
                                 (~is_upstream & up_rx_l0s));
    wire [NPORT-1:0] l1_cond  = is_upstream & aspm_l1_en & dn_all_l1 &
                                ~tlp_pending & ~dllp_pending & replay_empty &
                                rx_idle & max_credit_ok;
    wire [NPORT-1:0] dn_accept = aspm_l1_en & ~tlp_pending & ~acknak_pending;
    wire [NPORT-1:0] l0s_done;
    wire [NPORT-1:0] l1_done;

    // partner exit signals, delayed cycle counts kept far below the 1 us bound
    // a tlp without credit is not scheduled, so it must not pull the port out of l0s
    wire [NPORT-1:0] l0s_exit_req = (tlp_pending & tlp_credit_ok) | dllp_pending |
        (is_upstream & {NPORT{any_dn_l0s_exit}}) |
        (~is_upstream & {NPORT{any_up_l0s_exit}});
    wire [NPORT-1:0] l1_exit_req = tlp_pending |
        (is_upstream & {NPORT{any_dn_l1_exit}}) |
        (~is_upstream & {NPORT{any_up_l1_exit}});

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            alc_qual_timer #(.CNT_W(CNT_W)) u_l0s (
                .clk    (clk),
                .arst_n (arst_n),
                .cond   (l0s_cond[gi] && st[gi] == alc_pkg::ALC_TX_L0),
                .count  (CNT_W'(L0S_CYC - 1)),
                .done   (l0s_done[gi])
            );
            alc_qual_timer #(.CNT_W(CNT_W)) u_l1 (
                .clk    (clk),
                .arst_n (arst_n),
                .cond   (l1_cond[gi] && (st[gi] == alc_pkg::ALC_TX_L0 ||
                                         st[gi] == alc_pkg::ALC_TX_L0S)),
                .count  (CNT_W'(L1_CYC - 1)),
                .done   (l1_done[gi])
            );
            assign in_l1[gi] = (st[gi] == alc_pkg::ALC_TX_L1);

            // ----------------------------------------------------
            // transmit state machine, hardware only
            // ----------------------------------------------------
            always_comb begin
                next_st[gi] = st[gi];
                unique case (st[gi])
                    alc_pkg::ALC_TX_L0: begin
                        if (is_upstream[gi] && l1_done[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L1_REQ;
                        end else if (!is_upstream[gi] && rx_l1_req[gi]) begin
                            next_st[gi] = dn_accept[gi] ? alc_pkg::ALC_TX_L1_ACK
                                                        : alc_pkg::ALC_TX_NAK;
                        end else if (l0s_done[gi] && l0s_cond[gi] && !l0s_exit_req[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0S;
                        end
                    end
                    alc_pkg::ALC_TX_L0S: begin
                        if (l0s_exit_req[gi] || !l0s_cond[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end else if (is_upstream[gi] && l1_done[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L1_REQ;
                        end else if (!is_upstream[gi] && rx_l1_req[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end
                    end
                    alc_pkg::ALC_TX_L1_REQ: begin
                        if (rx_pm_ack[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L1;
                        end else if (rx_l1_decline[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end else if (l1_exit_req[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end
                    end
                    alc_pkg::ALC_TX_L1_ACK: begin
                        if (rx_eios[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L1;
                        end else if (tlp_pending[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end
                    end
                    alc_pkg::ALC_TX_NAK: begin
                        if (nak_sent[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end
                    end
                    alc_pkg::ALC_TX_L1: begin
                        if (l1_exit_req[gi]) begin
                            next_st[gi] = alc_pkg::ALC_TX_L0;
                        end
                    end
                endcase
                // link down forces l0 here too, so the registered outputs agree with st
                if (!link_up[gi]) begin
                    next_st[gi] = alc_pkg::ALC_TX_L0;
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    st[gi] <= alc_pkg::ALC_TX_L0;
                end else if (!link_up[gi]) begin
                    st[gi] <= alc_pkg::ALC_TX_L0;
                end else begin
                    st[gi] <= next_st[gi];
                end
            end

            // ----------------------------------------------------
            // registered outputs
            // ----------------------------------------------------
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tx_l0s[gi]         <= 1'b0;
                    rx_l0s[gi]         <= 1'b0;
                    link_l1[gi]        <= 1'b0;
                    send_l1_req[gi]    <= 1'b0;
                    send_pm_ack[gi]    <= 1'b0;
                    send_nak[gi]       <= 1'b0;
                    l1_exit_start[gi]  <= 1'b0;
                    l0s_exit_start[gi] <= 1'b0;
                end else begin
                    tx_l0s[gi]  <= (next_st[gi] == alc_pkg::ALC_TX_L0S);
                    // receive side tracks the partner regardless of enables
                    rx_l0s[gi]  <= rx_elec_idle[gi] & link_up[gi] &
                                   (next_st[gi] != alc_pkg::ALC_TX_L1);
                    link_l1[gi] <= (next_st[gi] == alc_pkg::ALC_TX_L1);
                    send_l1_req[gi] <= (next_st[gi] == alc_pkg::ALC_TX_L1_REQ);
                    send_pm_ack[gi] <= (next_st[gi] == alc_pkg::ALC_TX_L1_ACK);
                    // single pulse on entry to the reject state
                    send_nak[gi] <= (next_st[gi] == alc_pkg::ALC_TX_NAK) &&
                                    (st[gi] != alc_pkg::ALC_TX_NAK);
                    l1_exit_start[gi] <= (st[gi] == alc_pkg::ALC_TX_L1) &&
                                         (next_st[gi] == alc_pkg::ALC_TX_L0);
                    l0s_exit_start[gi] <= (st[gi] == alc_pkg::ALC_TX_L0S) &&
                                          (next_st[gi] == alc_pkg::ALC_TX_L0);
                end
            end
        end
    endgenerate

    // exit propagation takes two cycles, well inside EXIT_CYC
    logic unused_exit_cyc;
    assign unused_exit_cyc = (EXIT_CYC < 2);
endmodule : alc_aspm_ctrl

`default_nettype wire

/* design/alc_qual_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// qualification counter: done after cond held for count + 1 cycles
// ----------------------------------------------------------------
module alc_qual_timer #(
    parameter int CNT_W = 18
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] count,
    output var  logic             done
);
    logic [CNT_W-1:0] cnt;
    wire              at_end = (cnt == count);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= '0;
            done <= 1'b0;
        end else if (!cond) begin
            cnt  <= '0;     // any lapse restarts the interval
            done <= 1'b0;
        end else begin
            if (!at_end) begin
                cnt <= cnt + CNT_W'(1);
            end
            done <= at_end;
        end
    end
endmodule : alc_qual_timer

`default_nettype wire

/* inc/alc_cfg.svh */
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH

// aspm control field of the link control register, bit positions
`define ALC_ASPM_L0S_BIT   0
`define ALC_ASPM_L1_BIT    1
// clock period and qualification times
`define ALC_CLK_PERIOD_PS  5000
`define ALC_L0S_QUAL_NS    7000
`define ALC_L1_QUAL_NS     1000000
`define ALC_L1_EXIT_MAX_NS 1000
// least time rounds up, longest time rounds down
`define ALC_L0S_QUAL_CYC   ((`ALC_L0S_QUAL_NS * 1000 + `ALC_CLK_PERIOD_PS - 1) / `ALC_CLK_PERIOD_PS)
`define ALC_L1_QUAL_CYC    ((`ALC_L1_QUAL_NS * 1000 + `ALC_CLK_PERIOD_PS - 1) / `ALC_CLK_PERIOD_PS)
`define ALC_L1_EXIT_CYC    ((`ALC_L1_EXIT_MAX_NS * 1000) / `ALC_CLK_PERIOD_PS)

`endif

/* inc/alc_pkg.sv */
package alc_pkg;
    // transmit side link state of one port
    typedef enum logic [2:0] {
        ALC_TX_L0,
        ALC_TX_L0S,
        ALC_TX_L1_REQ,
        ALC_TX_L1,
        ALC_TX_L1_ACK,
        ALC_TX_NAK
    } alc_tx_e;
endpackage : alc_pkg
